// >>> ipsw_pkg.sv
// Shared constants, types and helpers for the interrupt priority and standby wake block
package ipsw_pkg;

  localparam int NSRC = 24;
  localparam int NVEC = 10;
  localparam int NXV  = 2;              // Vectors whose upper level is highest rather than high

  // Priority levels; a larger code wins
  typedef logic [1:0] ipsw_lvl_t;
  localparam ipsw_lvl_t LVL_NONE = 2'h0;
  localparam ipsw_lvl_t LVL_LOW  = 2'h1;
  localparam ipsw_lvl_t LVL_HIGH = 2'h2;
  localparam ipsw_lvl_t LVL_TOP  = 2'h3;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_PAUSE = 2'b01,
    ST_DEEP  = 2'b10,
    ST_XKEEP = 2'b11
  } ipsw_mode_t;

  // Source grouping: first source index and source count of each vector
  localparam logic [4:0] VEC_FIRST [NVEC] = '{5'h00, 5'h01, 5'h02, 5'h06, 5'h0a,
                                              5'h0b, 5'h0d, 5'h0f, 5'h11, 5'h14};
  localparam logic [2:0] VEC_CNT [NVEC]   = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h1,
                                              3'h2, 3'h2, 3'h2, 3'h3, 3'h4};
  localparam logic [16:0] VEC_BASE  = 17'h00003;
  localparam int          VEC_SHIFT = 3;       // Eight bytes between vector entries

  // Source indices that matter for wake-up
  localparam int SRC_EXT0   = 0;
  localparam int SRC_EXT1   = 1;
  localparam int SRC_EXT2   = 2;
  localparam int SRC_EXT4   = 4;
  localparam int SRC_REMOTE = 5;
  localparam int SRC_EXT5   = 7;
  localparam int SRC_BT0    = 8;
  localparam int SRC_BT1    = 9;
  localparam int SRC_PORT0  = 20;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_LEVEL  = 8'h08;
  localparam logic [7:0] OFS_FLAGS  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_VFLAGS = 8'h14;
  localparam logic [7:0] OFS_OSC    = 8'h18;

  // Field positions and reset values
  localparam int CTRL_EN    = 0;
  localparam int CTRL_LVL0  = 1;
  localparam int CTRL_LVL1  = 2;
  localparam int CTRL_MD_LO = 4;
  localparam int CTRL_MD_HI = 5;
  localparam int OSC_CF     = 0;
  localparam int OSC_RC     = 1;
  localparam int OSC_XT     = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [2:0] OSC_RST  = 3'h2;      // RC runs, CF and crystal stopped

  // Flags of the sources sharing vector v, low source first
  function automatic logic [3:0] vec_slice(input logic [NSRC-1:0] f, input int v);
    logic [3:0] s;
    s = 4'h0;
    for (int k = 0; k < 4; k++)
      if (k < int'(VEC_CNT[v]))
        s[k] = f[int'(VEC_FIRST[v]) + k];
    return s;
  endfunction

  // Level of the deepest nesting in service
  function automatic ipsw_lvl_t lvl_of(input logic [2:0] isr);
    if (isr[2])      return LVL_TOP;
    else if (isr[1]) return LVL_HIGH;
    else if (isr[0]) return LVL_LOW;
    else             return LVL_NONE;
  endfunction

endpackage

// >>> ipsw_arb_if.sv
// Interface between the control logic and the vector arbiter
`timescale 1ns/1ps
interface ipsw_arb_if;
  logic [9:0]         pend;
  logic [19:0]        lvl;
  ipsw_pkg::ipsw_lvl_t cur;
  logic               gnt;
  logic [3:0]         gnt_vec;
  ipsw_pkg::ipsw_lvl_t gnt_lvl;

  modport arb (input pend, input lvl, input cur, output gnt, output gnt_vec, output gnt_lvl);
  modport ctl (output pend, output lvl, output cur, input gnt, input gnt_vec, input gnt_lvl);
endinterface

// >>> ipsw_arbiter.sv
// Level and vector arbitration of pending requests
`timescale 1ns/1ps
module ipsw_arbiter (
  ipsw_arb_if.arb a
);

  // Ascending scan with a strict compare keeps the smallest vector on ties
  always_comb
  begin
    ipsw_pkg::ipsw_lvl_t best;
    ipsw_pkg::ipsw_lvl_t l;
    best      = a.cur;
    l         = ipsw_pkg::LVL_NONE;
    a.gnt     = 1'b0;
    a.gnt_vec = 4'h0;
    a.gnt_lvl = ipsw_pkg::LVL_NONE;
    for (int v = 0; v < ipsw_pkg::NVEC; v++)
    begin
      l = a.lvl[2*v +: 2];
      if (a.pend[v] && l > best)
      begin
        best      = l;
        a.gnt     = 1'b1;
        a.gnt_vec = 4'(v);
        a.gnt_lvl = l;
      end
    end
  end

endmodule // ipsw_arbiter

// >>> ipsw_standby.sv
// Standby mode sequencer and oscillator gating
`timescale 1ns/1ps
module ipsw_standby (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               enter,
  input  wire ipsw_pkg::ipsw_mode_t enter_mode,
  input  wire logic               pause_wake,
  input  wire logic               deep_wake,
  input  wire logic               xkeep_wake,
  input  wire logic [2:0]         osc_sw,
  output ipsw_pkg::ipsw_mode_t    mode_r,
  output logic                    run_core_r,
  output logic                    run_periph_r,
  output logic                    run_keep_r,
  output logic [2:0]              osc_en_r
);

  ipsw_pkg::ipsw_mode_t mode_nxt;
  logic                 xt_keep_r;
  logic                 xt_keep_nxt;
  logic                 run_core_nxt;
  logic                 run_periph_nxt;
  logic                 run_keep_nxt;
  logic [2:0]           osc_en_nxt;

  // Mode transitions; reset wake is the sys_rst path itself
  always_comb
  begin
    mode_nxt    = mode_r;
    xt_keep_nxt = xt_keep_r;
    case (mode_r)
      ipsw_pkg::ST_RUN:
        if (enter)
        begin
          mode_nxt    = enter_mode;
          xt_keep_nxt = osc_sw[ipsw_pkg::OSC_XT];
        end
      ipsw_pkg::ST_PAUSE: if (pause_wake) mode_nxt = ipsw_pkg::ST_RUN;
      ipsw_pkg::ST_DEEP:  if (deep_wake)  mode_nxt = ipsw_pkg::ST_RUN;
      ipsw_pkg::ST_XKEEP: if (xkeep_wake) mode_nxt = ipsw_pkg::ST_RUN;
      default:            mode_nxt = ipsw_pkg::ST_RUN;
    endcase
    run_core_nxt   = (mode_nxt == ipsw_pkg::ST_RUN);
    run_periph_nxt = run_core_nxt || mode_nxt == ipsw_pkg::ST_PAUSE;
    run_keep_nxt   = run_periph_nxt || mode_nxt == ipsw_pkg::ST_XKEEP;
    // Pause leaves every oscillator as software set it
    case (mode_nxt)
      ipsw_pkg::ST_DEEP:  osc_en_nxt = 3'h0;
      ipsw_pkg::ST_XKEEP: osc_en_nxt = {xt_keep_nxt, 2'b00};
      default:            osc_en_nxt = osc_sw;
    endcase
  end

  // State registers; a system reset stops CF and crystal
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_r       <= ipsw_pkg::ST_RUN;
      xt_keep_r    <= 1'b0;
      run_core_r   <= 1'b1;
      run_periph_r <= 1'b1;
      run_keep_r   <= 1'b1;
      osc_en_r     <= ipsw_pkg::OSC_RST;
    end
    else
    begin
      mode_r       <= mode_nxt;
      xt_keep_r    <= xt_keep_nxt;
      run_core_r   <= run_core_nxt;
      run_periph_r <= run_periph_nxt;
      run_keep_r   <= run_keep_nxt;
      osc_en_r     <= osc_en_nxt;
    end
  end

endmodule // ipsw_standby

// >>> ipsw_top.sv
// Interrupt priority controller with standby wake logic and an AHB-Lite register slave
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

module ipsw_top (
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Request sources and resets
  input  wire logic [23:0] src_req,
  input  wire logic        reset_pin_n,
  input  wire logic        wdt_reset,
  // Core side
  input  wire logic        vec_take,
  input  wire logic        int_return,
  output logic             vec_valid,
  output logic [16:0]      vec_addr,
  output logic [1:0]       vec_level,
  output logic [3:0]       vector_source_flags,
  output logic             run_core,
  output logic             run_periph,
  output logic             run_keep,
  output logic             cf_osc_en,
  output logic             rc_osc_en,
  output logic             xt_osc_en
);

  ipsw_arb_if arb ();

  // Reset pin synchroniser
  logic pin_s1_r;
  logic pin_s2_r;
  logic sys_rst;

  // Bus state
  logic        ap;
  logic        wr_r;
  logic [7:0]  addr_r;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic        hreadyout_r;

  // Software registers
  logic [2:0]  ctl_r;
  logic [2:0]  ctl_nxt;
  logic [23:0] en_r;
  logic [23:0] en_nxt;
  logic [9:0]  lvl_r;
  logic [9:0]  lvl_nxt;
  logic [2:0]  osc_r;
  logic [2:0]  osc_nxt;
  logic [23:0] flag_r;
  logic [23:0] flag_nxt;
  logic        enter;
  ipsw_pkg::ipsw_mode_t enter_mode;

  // Core handshake state
  logic [2:0]  isr_r;
  logic [2:0]  isr_nxt;
  logic        vv_r;
  logic        vv_nxt;
  logic [16:0] va_r;
  logic [16:0] va_nxt;
  logic [1:0]  vl_r;
  logic [1:0]  vl_nxt;
  logic [3:0]  vf_r;
  logic [3:0]  vf_nxt;
  logic [3:0]  vi_r;
  logic [3:0]  vi_nxt;
  logic        take;

  // Standby side
  logic [23:0] fe;
  logic        pause_wake;
  logic        deep_wake;
  logic        xkeep_wake;
  ipsw_pkg::ipsw_mode_t mode;
  logic [2:0]  osc_en;

  // Two flops before the reset pin is used; it never looks at the first stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= reset_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Any of the three reset causes clears every register except the pin synchroniser, which only rst clears
  assign sys_rst = rst | ~pin_s2_r | wdt_reset;

  // Address phase is accepted only when the bus is ready
  assign ap = hsel & htrans[1] & hready;

  // Read data is muxed at the address phase so hrdata comes from a flop
  always_comb
  begin
    case (haddr[7:0])
      ipsw_pkg::OFS_CTRL:   rd_mux = {29'h0, ctl_r};
      ipsw_pkg::OFS_ENABLE: rd_mux = {8'h0, en_r};
      ipsw_pkg::OFS_LEVEL:  rd_mux = {22'h0, lvl_r};
      ipsw_pkg::OFS_FLAGS:  rd_mux = {8'h0, flag_r};
      ipsw_pkg::OFS_STATUS: rd_mux = {21'h0, osc_en, run_keep, run_periph, run_core, isr_r, mode};
      ipsw_pkg::OFS_VFLAGS: rd_mux = {24'h0, vi_r, vf_r};
      ipsw_pkg::OFS_OSC:    rd_mux = {29'h0, osc_r};
      default:              rd_mux = 32'h0;
    endcase
    hrdata_nxt = (ap && !hwrite) ? rd_mux : hrdata_r;
  end

  // Bus registers; the slave never waits and always answers OKAY
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_r        <= 1'b0;
      addr_r      <= 8'h0;
      hrdata_r    <= 32'h0;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      wr_r        <= ap & hwrite;
      addr_r      <= ap ? haddr[7:0] : addr_r;
      hrdata_r    <= hrdata_nxt;
      hreadyout_r <= 1'b1;
    end
  end

  // Register writes land in the data phase; a source event beats a clear
  always_comb
  begin
    ctl_nxt    = ctl_r;
    en_nxt     = en_r;
    lvl_nxt    = lvl_r;
    osc_nxt    = osc_r;
    flag_nxt   = flag_r;
    enter      = 1'b0;
    enter_mode = ipsw_pkg::ST_RUN;
    if (wr_r)
    begin
      case (addr_r)
        ipsw_pkg::OFS_CTRL:
        begin
          ctl_nxt    = hwdata[2:0];
          enter_mode = ipsw_pkg::ipsw_mode_t'(hwdata[ipsw_pkg::CTRL_MD_HI:ipsw_pkg::CTRL_MD_LO]);
          enter      = enter_mode != ipsw_pkg::ST_RUN;
        end
        ipsw_pkg::OFS_ENABLE: en_nxt   = hwdata[23:0];
        ipsw_pkg::OFS_LEVEL:  lvl_nxt  = hwdata[9:0];
        ipsw_pkg::OFS_FLAGS:  flag_nxt = flag_r & ~hwdata[23:0];
        ipsw_pkg::OFS_OSC:    osc_nxt  = hwdata[2:0];
        default:              ;
      endcase
    end
    flag_nxt = flag_nxt | src_req;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctl_r  <= ipsw_pkg::CTRL_RST;
      en_r   <= 24'h0;
      lvl_r  <= 10'h0;
      osc_r  <= ipsw_pkg::OSC_RST;
      flag_r <= 24'h0;
    end
    else
    begin
      ctl_r  <= ctl_nxt;
      en_r   <= en_nxt;
      lvl_r  <= lvl_nxt;
      osc_r  <= osc_nxt;
      flag_r <= flag_nxt;
    end
  end

  // Fold enabled sources onto vectors and give each vector its level
  assign fe = flag_r & en_r;
  always_comb
  begin
    for (int v = 0; v < ipsw_pkg::NVEC; v++)
    begin
      arb.pend[v] = |ipsw_pkg::vec_slice(fe, v);
      if (!lvl_r[v])
        arb.lvl[2*v +: 2] = ipsw_pkg::LVL_LOW;
      else if (v < ipsw_pkg::NXV)
        arb.lvl[2*v +: 2] = ipsw_pkg::LVL_TOP;
      else
        arb.lvl[2*v +: 2] = ipsw_pkg::LVL_HIGH;
    end
    arb.cur = ipsw_pkg::lvl_of(isr_r);
  end

  ipsw_arbiter u_arb (
    .a (arb)
  );

  // Vector offer and nesting; a taken offer drops at once so it is not seen twice
  assign take = vec_take & vv_r;
  always_comb
  begin
    isr_nxt = isr_r;
    vf_nxt  = vf_r;
    vi_nxt  = vi_r;
    if (int_return)
    begin
      if (isr_r[2])      isr_nxt[2] = 1'b0;
      else if (isr_r[1]) isr_nxt[1] = 1'b0;
      else               isr_nxt[0] = 1'b0;
    end
    if (take)
    begin
      isr_nxt[vl_r - 2'h1] = 1'b1;
      vf_nxt = ipsw_pkg::vec_slice(fe, int'(vi_r));
    end
    // Offers only while executing, so a woken core arbitrates as usual;
    // no offer in the cycle a standby request lands, since the core stops at that edge
    vv_nxt = arb.gnt & ctl_r[ipsw_pkg::CTRL_EN] & run_core & ~enter & ~take & ~int_return;
    va_nxt = 17'(ipsw_pkg::VEC_BASE + (17'(arb.gnt_vec) << ipsw_pkg::VEC_SHIFT));
    vl_nxt = arb.gnt_lvl;
    if (!take)
      vi_nxt = vv_nxt ? arb.gnt_vec : vi_r;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      isr_r <= 3'h0;
      vv_r  <= 1'b0;
      va_r  <= ipsw_pkg::VEC_BASE;
      vl_r  <= ipsw_pkg::LVL_NONE;
      vf_r  <= 4'h0;
      vi_r  <= 4'h0;
    end
    else
    begin
      isr_r <= isr_nxt;
      vv_r  <= vv_nxt;
      va_r  <= va_nxt;
      vl_r  <= vl_nxt;
      vf_r  <= vf_nxt;
      vi_r  <= vi_nxt;
    end
  end

  // Wake causes; reset-pin and watchdog wakes go through sys_rst
  assign pause_wake = arb.gnt & ctl_r[ipsw_pkg::CTRL_EN];
  assign deep_wake  = (fe[ipsw_pkg::SRC_EXT0] & ctl_r[ipsw_pkg::CTRL_LVL0])
                    | (fe[ipsw_pkg::SRC_EXT1] & ctl_r[ipsw_pkg::CTRL_LVL1])
                    | fe[ipsw_pkg::SRC_EXT2] | fe[ipsw_pkg::SRC_EXT4]
                    | fe[ipsw_pkg::SRC_EXT5] | fe[ipsw_pkg::SRC_PORT0];
  assign xkeep_wake = deep_wake | fe[ipsw_pkg::SRC_BT0] | fe[ipsw_pkg::SRC_BT1]
                    | fe[ipsw_pkg::SRC_REMOTE];

  ipsw_standby u_sb (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .enter        (enter),
    .enter_mode   (enter_mode),
    .pause_wake   (pause_wake),
    .deep_wake    (deep_wake),
    .xkeep_wake   (xkeep_wake),
    .osc_sw       (osc_r),
    .mode_r       (mode),
    .run_core_r   (run_core),
    .run_periph_r (run_periph),
    .run_keep_r   (run_keep),
    .osc_en_r     (osc_en)
  );

  // Outputs, each from a flop except hresp, which is tied to OKAY
  assign hreadyout           = hreadyout_r;
  assign hrdata              = hrdata_r;
  assign hresp               = 1'b0;
  assign vec_valid           = vv_r;
  assign vec_addr            = va_r;
  assign vec_level           = vl_r;
  assign vector_source_flags = vf_r;
  assign cf_osc_en           = osc_en[ipsw_pkg::OSC_CF];
  assign rc_osc_en           = osc_en[ipsw_pkg::OSC_RC];
  assign xt_osc_en           = osc_en[ipsw_pkg::OSC_XT];

endmodule // ipsw_top

// >>> ipsw_chk.sv
// Port-level assertions for the interrupt priority and standby wake block
`timescale 1ns/1ps
module ipsw_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wdt_reset,
  input wire logic        vec_take,
  input wire logic        vec_valid,
  input wire logic [16:0] vec_addr,
  input wire logic [1:0]  vec_level,
  input wire logic        run_core,
  input wire logic        run_periph,
  input wire logic        run_keep,
  input wire logic        cf_osc_en,
  input wire logic        rc_osc_en,
  input wire logic        xt_osc_en
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Offers carry a real level and a legal vector entry
  offer_level_a: assert property (vec_valid |-> vec_level inside {2'h1, 2'h2, 2'h3})
    else $error("offer with empty level");
  offer_addr_a: assert property (vec_valid |-> vec_addr[2:0] == 3'h3 && vec_addr <= 17'h0004b)
    else $error("offer address off the vector grid");
  // A taken vector is withdrawn, no equal-level repeat
  take_drop_a: assert property (vec_valid && vec_take |=> !vec_valid)
    else $error("offer stayed after take");
  offer_run_a: assert property (vec_valid |-> run_core)
    else $error("offer while core stopped");
  // Standby entry and watchdog reset effects on the oscillators
  pause_osc_a: assert property ($fell(run_core) && run_periph |-> $stable({cf_osc_en, rc_osc_en, xt_osc_en}))
    else $error("pause changed an oscillator");
  deep_osc_a: assert property (!run_core && !run_periph && !run_keep |-> !cf_osc_en && !rc_osc_en && !xt_osc_en)
    else $error("oscillator running in deep stop");
  xkeep_osc_a: assert property ($fell(run_periph) && run_keep && !run_core |->
    !cf_osc_en && !rc_osc_en && xt_osc_en == $past(xt_osc_en))
    else $error("crystal stop oscillator state wrong");
  wdt_osc_a: assert property (wdt_reset |=> !cf_osc_en && !xt_osc_en && run_core)
    else $error("watchdog reset left oscillator or pause");
endmodule // ipsw_chk

bind ipsw_top ipsw_chk u_chk (.clk(clk), .rst(rst), .wdt_reset(wdt_reset), .vec_take(vec_take),
  .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_level(vec_level), .run_core(run_core),
  .run_periph(run_periph), .run_keep(run_keep), .cf_osc_en(cf_osc_en), .rc_osc_en(rc_osc_en),
  .xt_osc_en(xt_osc_en));

// >>> ipsw_core_model.sv
// Behavioural CPU core that takes offered vectors after a chosen delay
`timescale 1ns/1ps
module ipsw_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       vec_valid,
  input  wire logic [1:0] dly,
  output logic            vec_take
);
  logic [1:0] wait_r;

  // Take is a one-cycle pulse; a slow core lets the offer stand longer
  always @(posedge clk)
    if (rst || vec_valid !== 1'b1 || vec_take)
    begin
      vec_take <= 1'b0;
      wait_r   <= 2'h0;
    end
    else if (wait_r == dly)
      vec_take <= 1'b1;
    else
      wait_r <= wait_r + 2'h1;
endmodule // ipsw_core_model

// >>> interrupt_priority_standby_wake_bench.sv
// Self-checking bench for the interrupt priority and standby wake block
`timescale 1ns/1ps
module interrupt_priority_standby_wake_bench;
  logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0, wdt_reset = 1'b0, int_return = 1'b0, reset_pin_n = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, dly = 2'h0, vec_level;
  logic [23:0] src_req = 24'h0;
  logic [16:0] vec_addr;
  logic [3:0]  vector_source_flags;
  logic [22:0] note;
  logic        hreadyout, hresp, vec_take, vec_valid, run_core, run_periph, run_keep;
  logic        cf_osc_en, rc_osc_en, xt_osc_en, fl_due = 1'b0;
  logic [22:0] exp_q[$];
  int          n_mismatch = 0, n_tests = 0;

  always #5 clk = ~clk;

  ipsw_top uut (.clk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .src_req, .reset_pin_n, .wdt_reset,
    .vec_take, .int_return, .vec_valid, .vec_addr, .vec_level, .vector_source_flags, .run_core,
    .run_periph, .run_keep, .cf_osc_en, .rc_osc_en, .xt_osc_en);
  ipsw_core_model core (.clk, .rst, .vec_valid, .dly, .vec_take);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Single AHB-Lite word transfer; waits on hready in both phases
  // No wait limit here: only the hang guard ends a stalled transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task automatic pulse(input logic [23:0] m);
    src_req <= m;
    @(posedge clk);
    src_req <= 24'h0;
    @(posedge clk);
  endtask

  // Note the expected vector, then wait for the core to take it
  task automatic expect_take(input int v, input logic [1:0] l, input logic [3:0] f);
    exp_q.push_back({17'h00003 + 17'(v) * 17'h00008, l, f});
    do @(negedge clk); while (!(vec_valid === 1'b1 && vec_take === 1'b1));
    check(32'(run_core), 32'h1);
    @(posedge clk);
  endtask

  // Service routine end: clear the source flags, then return
  task automatic finish_isr(input logic [23:0] clr);
    bus(1'b1, ipsw_pkg::OFS_FLAGS, {8'h0, clr});
    int_return <= 1'b1;
    @(posedge clk);
    int_return <= 1'b0;
    @(posedge clk);
  endtask

  // Standby outputs as run core/periph/keep and cf/rc/xt enables
  task automatic sb_check(input logic [5:0] e, output logic [31:0] s);
    repeat (2) @(negedge clk);
    s = {26'h0, run_core, run_periph, run_keep, cf_osc_en, rc_osc_en, xt_osc_en};
    check(s, {26'h0, e});
    @(posedge clk);
  endtask

  // Takes pop the oldest note; flags settle one cycle after the take
  always @(negedge clk)
  begin
    if (fl_due)
      check({28'h0, vector_source_flags}, {28'h0, note[3:0]});
    fl_due = 1'b0;
    if (vec_valid === 1'b1 && vec_take === 1'b1)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 23'h0;
      check({13'h0, vec_addr, vec_level}, {13'h0, note[22:4]});
      fl_due = 1'b1;
    end
  end

  // Hang guard, far above the expected run time
  initial
  begin
    #100us;
    n_mismatch++;
    results();
  end

  initial
  begin
    int k;
    void'($urandom(71));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, ipsw_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h000002e0);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h1);
    bus(1'b1, ipsw_pkg::OFS_ENABLE, 32'h00ffffff);
    $display("test reset done");
    // Every vector once, from a random source sharing it
    for (int v = 0; v < 10; v++)
    begin
      k = $urandom % int'(ipsw_pkg::VEC_CNT[v]);
      dly <= 2'($urandom % 4);
      pulse(24'h1 << (int'(ipsw_pkg::VEC_FIRST[v]) + k));
      expect_take(v, 2'h1, 4'h1 << k);
      finish_isr(24'h1 << (int'(ipsw_pkg::VEC_FIRST[v]) + k));
    end
    $display("test vector map done");
    // Same level: smaller vector first, the other waits for return
    pulse(24'h1 << 13 | 24'h1 << 20);
    expect_take(6, 2'h1, 4'h1);
    finish_isr(24'h1 << 13);
    expect_take(9, 2'h1, 4'h1);
    finish_isr(24'h1 << 20);
    // Level wins over address; only a higher level nests
    bus(1'b1, ipsw_pkg::OFS_LEVEL, 32'h201);
    pulse(24'h1 << 13 | 24'h1 << 20);
    expect_take(9, 2'h2, 4'h1);
    pulse(24'h1);
    expect_take(0, 2'h3, 4'h1);
    finish_isr(24'h1);
    finish_isr(24'h1 << 20);
    expect_take(6, 2'h1, 4'h1);
    finish_isr(24'h1 << 13);
    // Last entry was vector 6 from its lower source
    bus(1'b0, ipsw_pkg::OFS_VFLAGS, 32'h0);
    check(rd, 32'h00000061);
    $display("test priority done");
    // Pause: core stops, oscillators untouched, any request wakes
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h11);
    sb_check(6'h1a, rd);
    pulse(24'h1 << 23);
    expect_take(9, 2'h2, 4'h8);
    finish_isr(24'h1 << 23);
    $display("test pause done");
    // Deep stop: edge ext0 and timer do not wake, port 0 does
    bus(1'b1, ipsw_pkg::OFS_OSC, 32'h7);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h21);
    sb_check(6'h00, rd);
    pulse(24'h1);
    pulse(24'h1 << 3);
    sb_check(6'h00, rd);
    pulse(24'h1 << 20);
    expect_take(0, 2'h3, 4'h1);
    finish_isr(24'h1);
    expect_take(9, 2'h2, 4'h1);
    finish_isr(24'h1 << 20);
    expect_take(2, 2'h1, 4'h2);
    finish_isr(24'h1 << 3);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h23);
    sb_check(6'h00, rd);
    pulse(24'h1);
    expect_take(0, 2'h3, 4'h1);
    finish_isr(24'h1);
    // Ext one with its level bit wakes as well
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h25);
    sb_check(6'h00, rd);
    pulse(24'h2);
    expect_take(1, 2'h1, 4'h1);
    finish_isr(24'h2);
    $display("test deep stop done");
    // Crystal stop, crystal running then stopped at entry
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h31);
    sb_check(6'h09, rd);
    pulse(24'h1 << 23);
    sb_check(6'h09, rd);
    pulse(24'h1 << 8);
    expect_take(9, 2'h2, 4'h8);
    finish_isr(24'h1 << 23);
    expect_take(3, 2'h1, 4'h4);
    finish_isr(24'h1 << 8);
    bus(1'b1, ipsw_pkg::OFS_OSC, 32'h3);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h31);
    sb_check(6'h08, rd);
    pulse(24'h1 << 5);
    expect_take(2, 2'h1, 4'h8);
    finish_isr(24'h1 << 5);
    $display("test crystal stop done");
    // Watchdog reset ends pause and stops the CF and crystal oscillators
    bus(1'b1, ipsw_pkg::OFS_OSC, 32'h7);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h11);
    sb_check(6'h1f, rd);
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    sb_check(6'h3a, rd);
    check(32'(exp_q.size()), 32'h0);
    $display("test watchdog done");
    // Reset pin ends pause; two synchroniser stages delay it
    bus(1'b1, ipsw_pkg::OFS_OSC, 32'h7);
    bus(1'b1, ipsw_pkg::OFS_CTRL, 32'h11);
    sb_check(6'h1f, rd);
    reset_pin_n <= 1'b0;
    @(posedge clk);
    reset_pin_n <= 1'b1;
    @(posedge clk);
    sb_check(6'h3a, rd);
    $display("test reset pin done");
    results();
  end
endmodule // interrupt_priority_standby_wake_bench
